// File: hw/lsb_driver.v
// The register offsets and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ps
`include "lsb_regs.vh"

// Overview of operation
// - master off forces all lcd pin and enable outputs ground
// - per-pin select works only when master on
// - control bits 3..0 select common pins
// - low segment register selects segments 0-7
// - mid segment register selects segments 8-15
// - high register selects 16-19, upper zero
// - frame bit picks frame 0 or 1
// - frame0: common vdd/third, segment vss/two-thirds
// - frame1: common vss/two-thirds, segment vdd/third
// - common polarity from port a bits 0,1,2,4
// - segment level from frame and data bit
// - drive ignores port direction settings
// - two-bit field selects drive current
// - control registers reset to zero, read/write
module lsb_driver (
    input wire mclk,
    input wire rst,
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    output reg [7:0] lcd_common_pins,
    output reg [39:0] lcd_segment_pins,
    output reg [3:0] lcd_pin_enable,
    output reg [19:0] lcd_segment_enable,
    output reg [1:0] drive_current_field
);

////////////////////////////////////////////////////////////////////////////
reg [7:0] ctrl_q;
reg [7:0] seg_lo_q;
reg [7:0] seg_mid_q;
reg [3:0] seg_hi_q;
reg [7:0] port_a_data_register_q;
reg [19:0] seg_data_q;
reg ack_q;
wire req;
wire wr_go;
wire [7:0] wb;
wire master_on;
wire frame;
wire [19:0] segment_pin_select;
wire [3:0] common_pin_select;
wire [3:0] port_a_common_data_bits;
wire [7:0] com_lvl;
wire [39:0] seg_lvl;

assign req = avs_read | avs_write;
assign wr_go = avs_write & ack_q;
assign wb = avs_writedata[7:0];
assign master_on = ctrl_q[`LSB_MASTER_BIT];
assign frame = ctrl_q[`LSB_FRAME_BIT];
assign common_pin_select = ctrl_q[`LSB_COM_HI:0];
assign segment_pin_select = {seg_hi_q, seg_mid_q, seg_lo_q};
assign port_a_common_data_bits = {port_a_data_register_q[4],
    port_a_data_register_q[2:0]};

////////////////////////////////////////////////////////////////////////////
// bus handshake: one wait cycle then accept
always @(posedge mclk or posedge rst) begin
    if (rst) begin
        ack_q <= 1'b0;
        avs_waitrequest <= 1'b1;
    end else begin
        ack_q <= req & ~ack_q;
        avs_waitrequest <= ~(req & ~ack_q);
    end
end

// register writes
always @(posedge mclk or posedge rst) begin
    if (rst) begin
        ctrl_q <= `LSB_RST_CTRL;
        seg_lo_q <= `LSB_RST_SEG;
        seg_mid_q <= `LSB_RST_SEG;
        seg_hi_q <= 4'h0;
        port_a_data_register_q <= `LSB_RST_PORT;
        seg_data_q <= `LSB_RST_SEGDAT;
    end else if (wr_go && avs_byteenable[0]) begin
        case (avs_address)
            `LSB_ADDR_CTRL: ctrl_q <= wb;
            `LSB_ADDR_SEG_LO: seg_lo_q <= wb;
            `LSB_ADDR_SEG_MID: seg_mid_q <= wb;
            `LSB_ADDR_SEG_HI: seg_hi_q <= wb[3:0];
            `LSB_ADDR_PORT_A: port_a_data_register_q <= wb;
            `LSB_ADDR_PORT_SEG: seg_data_q <= avs_writedata[19:0];
            default: ;
        endcase
    end
end

// read data
always @(posedge mclk or posedge rst) begin
    if (rst) begin
        avs_readdata <= 32'h00000000;
    end else if (avs_read && !ack_q) begin
        case (avs_address)
            `LSB_ADDR_CTRL: avs_readdata <= {24'h000000, ctrl_q};
            `LSB_ADDR_SEG_LO: avs_readdata <= {24'h000000, seg_lo_q};
            `LSB_ADDR_SEG_MID: avs_readdata <= {24'h000000, seg_mid_q};
            `LSB_ADDR_SEG_HI: avs_readdata <= {28'h0000000, seg_hi_q};
            `LSB_ADDR_PORT_A:
                avs_readdata <= {24'h000000, port_a_data_register_q};
            `LSB_ADDR_PORT_SEG: avs_readdata <= {12'h000, seg_data_q};
            `LSB_ADDR_STATUS:
                avs_readdata <= {24'h000000, lcd_pin_enable,
                    lcd_segment_enable[3:0]};
            default: avs_readdata <= 32'h00000000;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////
// level decode, one per pin
genvar gi;
generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_com
        lsb_pin_level u_com (
            .master_on(master_on),
            .pin_select(common_pin_select[gi]),
            .frame(frame),
            .is_common(1'b1),
            .data_bit(port_a_common_data_bits[gi]),
            .level(com_lvl[2*gi+1:2*gi])
        );
    end
    for (gi = 0; gi < 20; gi = gi + 1) begin : g_seg
        lsb_pin_level u_seg (
            .master_on(master_on),
            .pin_select(segment_pin_select[gi]),
            .frame(frame),
            .is_common(1'b0),
            .data_bit(seg_data_q[gi]),
            .level(seg_lvl[2*gi+1:2*gi])
        );
    end
endgenerate

////////////////////////////////////////////////////////////////////////////
// registered pin outputs
always @(posedge mclk or posedge rst) begin
    if (rst) begin
        lcd_common_pins <= 8'h00;
        lcd_segment_pins <= 40'h0000000000;
        lcd_pin_enable <= 4'h0;
        lcd_segment_enable <= 20'h00000;
        drive_current_field <= 2'h0;
    end else begin
        lcd_common_pins <= com_lvl;
        lcd_segment_pins <= seg_lvl;
        lcd_pin_enable <= master_on ? common_pin_select : 4'h0;
        lcd_segment_enable <= master_on ? segment_pin_select : 20'h00000;
        drive_current_field <= ctrl_q[`LSB_ISEL_HI:`LSB_ISEL_LO];
    end
end

endmodule

// File: hw/lsb_regs.vh
`ifndef LSB_REGS_VH
`define LSB_REGS_VH

// register word addresses (byte address = 4 * index)
`define LSB_ADDR_CTRL 4'h0
`define LSB_ADDR_SEG_LO 4'h1
`define LSB_ADDR_SEG_MID 4'h2
`define LSB_ADDR_SEG_HI 4'h3
`define LSB_ADDR_PORT_A 4'h4
`define LSB_ADDR_PORT_SEG 4'h5
`define LSB_ADDR_STATUS 4'h6

// control register fields
`define LSB_FRAME_BIT 7
`define LSB_ISEL_HI 6
`define LSB_ISEL_LO 5
`define LSB_MASTER_BIT 4
`define LSB_COM_HI 3
`define LSB_SEG_HI_MASK 8'h0f

// reset values
`define LSB_RST_CTRL 8'h00
`define LSB_RST_SEG 8'h00
`define LSB_RST_PORT 8'h00
`define LSB_RST_SEGDAT 20'h00000

// level codes driven to the analog stage
`define LSB_LVL_VSS 2'h0
`define LSB_LVL_THIRD 2'h1
`define LSB_LVL_TWO_THIRD 2'h2
`define LSB_LVL_VDD 2'h3

// avalon slave read latency in cycles of waitrequest
`define LSB_WAIT_CYCLES 1

`endif

// File: hw/lsb_pin_level.v
`timescale 1ns/1ps
`include "lsb_regs.vh"

module lsb_pin_level (
    input wire master_on,
    input wire pin_select,
    input wire frame,
    input wire is_common,
    input wire data_bit,
    output reg [1:0] level
);

always @* begin
    if (!master_on || !pin_select) begin
        level = `LSB_LVL_VSS;
    end else if (is_common ^ frame) begin
        level = data_bit ? `LSB_LVL_VDD : `LSB_LVL_THIRD;
    end else begin
        level = data_bit ? `LSB_LVL_VSS : `LSB_LVL_TWO_THIRD;
    end
end

endmodule

// File: testbench/lsb_lcd_panel.sv
`timescale 1ns/1ps
// glass model: pixel at common 0 and segment 0
module lsb_lcd_panel (
    input logic [7:0] lcd_common_pins,
    input logic [39:0] lcd_segment_pins,
    output logic lit
);
    assign lit = (lcd_common_pins[1:0] == 2'h3 && lcd_segment_pins[1:0] == 2'h0)
        || (lcd_common_pins[1:0] == 2'h0 && lcd_segment_pins[1:0] == 2'h3);
endmodule

// File: testbench/lsb_driver_assertions.sv
`timescale 1ns/1ps
module lsb_driver_assertions (
    input logic mclk,
    input logic rst,
    input logic [3:0] avs_address,
    input logic avs_read,
    input logic avs_write,
    input logic [31:0] avs_writedata,
    input logic [3:0] avs_byteenable,
    input logic [31:0] avs_readdata,
    input logic avs_waitrequest,
    input logic [7:0] lcd_common_pins,
    input logic [39:0] lcd_segment_pins,
    input logic [3:0] lcd_pin_enable,
    input logic [19:0] lcd_segment_enable,
    input logic [1:0] drive_current_field
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    wire rd_ok = avs_read && !avs_waitrequest;
    AST_COM_OFF: assert property (
        lcd_pin_enable == 4'h0 |-> lcd_common_pins == 8'h00) else $error("com");
    AST_SEG_OFF: assert property (
        lcd_segment_enable == 20'h0 |-> lcd_segment_pins == 40'h0) else $error("seg");
    AST_ANSWER: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("no answer");
    AST_PULSE: assert property (
        !avs_waitrequest |=> avs_waitrequest) else $error("wait low long");
    AST_HI_ZERO: assert property (
        rd_ok && avs_address == 4'h3 |-> avs_readdata[7:4] == 4'h0)
        else $error("hi bits");
    AST_UNMAPPED: assert property (
        rd_ok && avs_address > 4'h6 |-> avs_readdata == 32'h0) else $error("unm");
    AST_CURRENT: assert property (
        avs_write && !avs_waitrequest && avs_address == 4'h0 && avs_byteenable[0]
        |=> ##1 drive_current_field == $past(avs_writedata[6:5], 2))
        else $error("current");
    AST_PIN_CAUSE: assert property (
        $changed({lcd_common_pins, lcd_segment_pins})
        |-> $past(avs_write && !avs_waitrequest, 2)) else $error("pin change");
    cover property (lcd_pin_enable == 4'hf);
    cover property (lcd_common_pins == 8'hff);
    cover property (rd_ok);
endmodule
////////////////////////////////////////////////////////////////////////////
bind lsb_driver lsb_driver_assertions lsb_driver_assertions_i (.*);

// File: testbench/lsb_driver_bench.sv
`timescale 1ns/1ps
module lsb_driver_bench;
    logic mclk = 0, rst = 1, avs_read = 0, avs_write = 0, avs_waitrequest, lit;
    logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hf, lcd_pin_enable;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic [7:0] lcd_common_pins;
    logic [39:0] lcd_segment_pins;
    logic [19:0] lcd_segment_enable;
    logic [1:0] drive_current_field, lc, ls;
    integer miscompares = 0, cmp_count = 0, f, d;
    always #2.5 mclk = ~mclk;
    lsb_driver lsb_driver_i (.*);
    lsb_lcd_panel lsb_lcd_panel_i (.*);
    task chk(input string n, input [63:0] s, input [63:0] e);
        cmp_count++;
        if (s !== e) begin
            miscompares++;
            $display("mismatch %s exp %h seen %h", n, e, s);
        end
    endtask
    task end_of_test;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task acc(input [3:0] a, input w, input [31:0] dat);
        integer n;
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= dat;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 40);
        if (avs_waitrequest !== 1'b0) begin
            miscompares++;
            end_of_test;
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge mclk);
    endtask
    task pins(input [1:0] c, input [1:0] s);
        repeat (2) @(posedge mclk);
        chk("com", lcd_common_pins, {4{c}});
        chk("seg", lcd_segment_pins, {20{s}});
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        for (f = 0; f < 4; f++) begin
            acc(f[3:0], 1'b0, 32'h0);
            chk("reset", q, 32'h0);
        end
        acc(4'h0, 1'b1, 32'h0f);
        for (f = 1; f < 4; f++) acc(f[3:0], 1'b1, 32'hff);
        acc(4'h4, 1'b1, 32'hff);
        acc(4'h5, 1'b1, 32'hfffff);
        pins(2'h0, 2'h0);
        chk("en", {lcd_pin_enable, lcd_segment_enable}, 24'h0);
        acc(4'h3, 1'b0, 32'h0);
        chk("hi", q, 32'h0f);
        acc(4'h2, 1'b0, 32'h0);
        chk("mid", q, 32'hff);
        for (f = 0; f < 2; f++) for (d = 0; d < 2; d++) begin
            acc(4'h4, 1'b1, d ? 32'h17 : 32'he8);
            acc(4'h5, 1'b1, d ? 32'hfffff : 32'h0);
            acc(4'h0, 1'b1, {24'h0, f[0], f[0], d[0], 5'h1f});
            lc = f ? (d ? 2'h0 : 2'h2) : (d ? 2'h3 : 2'h1);
            ls = f ? (d ? 2'h3 : 2'h1) : (d ? 2'h0 : 2'h2);
            pins(lc, ls);
            chk("cur", drive_current_field, {f[0], d[0]});
            chk("lit", lit, d[0]);
        end
        acc(4'h1, 1'b1, 32'h01);
        acc(4'h2, 1'b1, 32'h0);
        acc(4'h3, 1'b1, 32'h0);
        acc(4'h0, 1'b1, 32'h15);
        repeat (2) @(posedge mclk);
        chk("pen", lcd_pin_enable, 4'h5);
        chk("sen", lcd_segment_enable, 20'h1);
        acc(4'h6, 1'b0, 32'h0);
        chk("status", q, 32'h51);
        acc(4'h5, 1'b0, 32'h0);
        chk("segdat", q, 32'hfffff);
        acc(4'hf, 1'b1, 32'hff);
        acc(4'hf, 1'b0, 32'h0);
        chk("unmapped", q, 32'h0);
        avs_byteenable <= 4'h0;
        acc(4'h0, 1'b1, 32'h0);
        avs_byteenable <= 4'hf;
        acc(4'h0, 1'b0, 32'h0);
        chk("be", q, 32'h15);
        acc(4'h0, 1'b1, 32'h0f);
        pins(2'h0, 2'h0);
        acc(4'h1, 1'b1, 32'ha5);
        rst <= 1'b1;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        acc(4'h0, 1'b0, 32'h0);
        chk("rst ctrl", q, 32'h0);
        acc(4'h1, 1'b0, 32'h0);
        chk("rst seg", q, 32'h0);
        end_of_test;
    end
endmodule
